// ===== hw/ssc_cfg.svh
// Constants for the single-slope conversion control block
// Assumes the 25 MHz sys_clk and a 16-bit capture timer
//
// What this block does
// - The edge flag sets only on a rising comparator-two output and cannot set again until that output has been low.
// - Clearing the charge enable stops the ramp and discharges the capacitor; the next source follows full discharge.
// - In modes two and three every event that sets the edge flag also captures the 16-bit timer, noise included.
// - In mode two an overflow event and in mode three a compare event starts a conversion even if the last is unfinished.
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH

`define SSC_CLK_PERIOD_NS 40
`define SSC_PRESCALE      8
`define SSC_TIMER_W       16
`define SSC_CHAN_W        3
`define SSC_DISCH_TIME_NS 100000
`define SSC_DISCH_CYCLES  ((`SSC_DISCH_TIME_NS + `SSC_CLK_PERIOD_NS - 1) / `SSC_CLK_PERIOD_NS)
`define SSC_CHAN_RST      3'h0

`endif

// ===== hw/ssc_pkg.sv
// Types for the single-slope conversion control block
// Assumes ssc_cfg.svh for all numeric constants
package ssc_pkg;

  typedef enum logic [1:0] {
    MODE_SOFT0,
    MODE_SOFT1,
    MODE_OVF_START,
    MODE_CMP_START
  } conv_mode_e;

  typedef enum logic [1:0] {
    RAMP_SETTLED,
    RAMP_CHARGING,
    RAMP_DISCHARGING
  } ramp_state_e;

endpackage : ssc_pkg

// ===== hw/ssc_timer.sv
// Free-running prescaled capture timer
// Assumes one clock; events leave as one-cycle pulses
`timescale 1ns/1ps
`include "ssc_cfg.svh"

module ssc_timer
  import ssc_pkg::*;
#(
  parameter int unsigned W        = `SSC_TIMER_W,
  parameter int unsigned PRESCALE = `SSC_PRESCALE
)
(
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // Compare setting
  input  wire logic [W-1:0] compare_value,
  // Timer state and events
  output logic      [W-1:0] count_q,
  output logic              overflow_pulse_q,
  output logic              compare_pulse_q
);

  logic [7:0]   pre_q;
  wire          tick     = (pre_q == 8'(PRESCALE - 1));
  wire  [W-1:0] count_nx = count_q + W'(1);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pre_q            <= 8'h00;
      count_q          <= '0;
      overflow_pulse_q <= 1'b0;
      compare_pulse_q  <= 1'b0;
    end
    else
    begin
      pre_q            <= tick ? 8'h00 : pre_q + 8'h01;
      count_q          <= tick ? count_nx : count_q;
      overflow_pulse_q <= tick && (count_q == '1);
      compare_pulse_q  <= tick && (count_nx == compare_value);
    end
  end

endmodule : ssc_timer

// ===== hw/single_slope_conversion_control.sv
// Ramp, edge flag, capture and start sequencing of a single-slope converter
// Assumes synchronous comparator input and software running the conversion steps
`timescale 1ns/1ps
`include "ssc_cfg.svh"

module single_slope_conversion_control
  import ssc_pkg::*;
#(
  parameter int unsigned TIMER_W     = `SSC_TIMER_W,
  parameter int unsigned CHAN_W      = `SSC_CHAN_W,
  parameter int unsigned DISCH_CYCLES = `SSC_DISCH_CYCLES
)
(
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // Configuration
  input  wire logic [1:0]         mode_sel,
  input  wire logic [TIMER_W-1:0] compare_value,
  // Software strobes
  input  wire logic               charge_set,
  input  wire logic               charge_clear,
  input  wire logic               edge_flag_clear,
  input  wire logic               capture_release,
  input  wire logic               overflow_flag_clear,
  input  wire logic               compare_flag_clear,
  input  wire logic               channel_write,
  input  wire logic [CHAN_W-1:0]  channel_data,
  // Analog side
  input  wire logic               comparator_two_output,
  output logic                    ramp_charge_enable_q,
  output logic                    ramp_discharge_q,
  output logic [CHAN_W-1:0]       channel_select_q,
  // Status
  output logic                    comparator_two_edge_flag_q,
  output logic                    input_capture_flag_q,
  output logic                    timer_overflow_flag_q,
  output logic                    output_compare_flag_q,
  output logic                    discharge_settled_q,
  output logic [TIMER_W-1:0]      capture_value_q,
  output logic [TIMER_W-1:0]      timer_value_q
);

  ramp_state_e        state_q;
  ramp_state_e        state_d;
  logic               comp_prev_q;
  logic [15:0]        disch_cnt_q;
  logic [TIMER_W-1:0] tmr_count;
  logic               tmr_ovf;
  logic               tmr_cmp;

  ssc_timer #(
    .W        (TIMER_W),
    .PRESCALE (`SSC_PRESCALE)
  ) u_timer (
    .sys_clk          (sys_clk),
    .rst              (rst),
    .compare_value    (compare_value),
    .count_q          (tmr_count),
    .overflow_pulse_q (tmr_ovf),
    .compare_pulse_q  (tmr_cmp)
  );

  // Event decode
  wire auto_mode   = mode_sel[1];
  wire comp_rise   = comparator_two_output & ~comp_prev_q;
  wire start_auto  = (mode_sel == MODE_OVF_START) ? tmr_ovf :
                     (mode_sel == MODE_CMP_START) ? tmr_cmp : 1'b0;
  wire capture_evt = auto_mode & comp_rise;
  wire charge_on   = start_auto | charge_set;
  wire charge_off  = charge_clear | capture_evt;
  wire charge_d    = charge_on | (ramp_charge_enable_q & ~charge_off);
  wire disch_done  = (disch_cnt_q == 16'(DISCH_CYCLES - 1));
  wire chan_take   = channel_write & (state_q == RAMP_SETTLED);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      RAMP_SETTLED:     if (charge_d) state_d = RAMP_CHARGING;
      RAMP_CHARGING:    if (!charge_d) state_d = RAMP_DISCHARGING;
      RAMP_DISCHARGING: if (charge_d) state_d = RAMP_CHARGING;
                        else if (disch_done) state_d = RAMP_SETTLED;
      default:          state_d = RAMP_SETTLED;
    endcase
  end

  // Ramp control and discharge timing
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q              <= RAMP_SETTLED;
      ramp_charge_enable_q <= 1'b0;
      ramp_discharge_q     <= 1'b1;
      discharge_settled_q  <= 1'b1;
      disch_cnt_q          <= 16'h0000;
      channel_select_q     <= `SSC_CHAN_RST;
    end
    else
    begin
      state_q              <= state_d;
      ramp_charge_enable_q <= charge_d;
      ramp_discharge_q     <= ~charge_d;
      discharge_settled_q  <= (state_d == RAMP_SETTLED);
      disch_cnt_q          <= (state_q == RAMP_DISCHARGING) ? disch_cnt_q + 16'h0001 : 16'h0000;
      if (chan_take)
        channel_select_q   <= channel_data;
    end
  end

  // Flags, set wins over clear
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      comp_prev_q                <= 1'b1;
      comparator_two_edge_flag_q <= 1'b0;
      input_capture_flag_q       <= 1'b0;
      timer_overflow_flag_q      <= 1'b0;
      output_compare_flag_q      <= 1'b0;
      capture_value_q            <= '0;
      timer_value_q              <= '0;
    end
    else
    begin
      comp_prev_q                <= comparator_two_output;
      comparator_two_edge_flag_q <= comp_rise | (comparator_two_edge_flag_q & ~edge_flag_clear);
      input_capture_flag_q       <= capture_evt | (input_capture_flag_q & ~capture_release);
      timer_overflow_flag_q      <= tmr_ovf | (timer_overflow_flag_q & ~overflow_flag_clear);
      output_compare_flag_q      <= tmr_cmp | (output_compare_flag_q & ~compare_flag_clear);
      timer_value_q              <= tmr_count;
      if (capture_evt)
        capture_value_q          <= tmr_count;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_flag_rise_only: assert property ($rose(comparator_two_edge_flag_q) |->
      $past(comparator_two_output) && !$past(comp_prev_q))
    else $error("edge flag set without a rising comparator output");

  a_flag_high_hold: assert property ((edge_flag_clear && comparator_two_output && comp_prev_q) |=>
      !comparator_two_edge_flag_q)
    else $error("edge flag set again while comparator stayed high");

  a_stop_discharge: assert property ($fell(ramp_charge_enable_q) |->
      ramp_discharge_q && !discharge_settled_q)
    else $error("ramp stop did not start discharge");

  a_chan_locked: assert property ((channel_write && !discharge_settled_q) |=>
      $stable(channel_select_q))
    else $error("source changed before discharge finished");

  a_capture_each: assert property (capture_evt |=>
      input_capture_flag_q && comparator_two_edge_flag_q && capture_value_q == $past(tmr_count))
    else $error("edge event in automated mode did not capture");

  a_auto_start: assert property (start_auto |=> ramp_charge_enable_q && !ramp_discharge_q)
    else $error("timer event did not start the ramp");

  c_auto_capture: cover property (capture_evt ##1 ramp_discharge_q);
  c_overlap:      cover property (start_auto && ramp_charge_enable_q);
  c_settle:       cover property ($rose(discharge_settled_q));

endmodule : single_slope_conversion_control

// ===== testbench/ramp_comparator_model.sv
// Ramp capacitor and comparator two behaviour
// Assumes one ramp step per clock while charging
`timescale 1ns/1ps
module ramp_comparator_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Ramp control and input level
  input  wire logic       charge_on,
  input  wire logic [7:0] threshold,
  input  wire logic       noise,
  // Comparator
  output logic            comp_out
);
  logic [7:0] level_q;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      level_q <= 8'h00;
    else if (charge_on)
      level_q <= (level_q == 8'hfe) ? level_q : level_q + 8'h01;
    else
      level_q <= (level_q < 8'h10) ? 8'h00 : level_q - 8'h10;
  end
  assign comp_out = noise | (level_q >= threshold);
endmodule : ramp_comparator_model

// ===== testbench/single_slope_conversion_control_test.sv
// Random and corner tests of the conversion control block
// Assumes an 8-bit timer and a short discharge count
`timescale 1ns/1ps
module single_slope_conversion_control_test;
  import ssc_pkg::*;
  logic       sys_clk, rst, noise, comp, ramp_charge_enable, dis, efl, input_capture_flag, ovf, output_compare_flag, setl;
  logic [1:0] mode;
  logic [7:0] cmpv, thr;
  logic [6:0] stb;
  logic [2:0] chan, chsel;
  int         n_mismatch, n_compared, n;
  wire  [2:0] obs = {ramp_charge_enable, setl, efl};
  single_slope_conversion_control #(.TIMER_W(8), .DISCH_CYCLES(4)) single_slope_conversion_control_inst (
    .sys_clk(sys_clk), .rst(rst), .mode_sel(mode), .compare_value(cmpv), .charge_set(stb[0]),
    .charge_clear(stb[1]), .edge_flag_clear(stb[2]), .capture_release(stb[3]), .overflow_flag_clear(stb[4]),
    .compare_flag_clear(stb[5]), .channel_write(stb[6]), .channel_data(chan), .comparator_two_output(comp),
    .ramp_charge_enable_q(ramp_charge_enable), .ramp_discharge_q(dis), .channel_select_q(chsel),
    .comparator_two_edge_flag_q(efl), .input_capture_flag_q(input_capture_flag), .timer_overflow_flag_q(ovf),
    .output_compare_flag_q(output_compare_flag), .discharge_settled_q(setl), .capture_value_q(), .timer_value_q());
  ramp_comparator_model ramp_comparator_model_inst (.sys_clk(sys_clk), .rst(rst), .charge_on(ramp_charge_enable),
    .threshold(thr), .noise(noise), .comp_out(comp));
  function automatic logic trip_ok(input int cyc, input int lvl);
    trip_ok = (cyc >= lvl - 1) && (cyc <= lvl + 4);
  endfunction : trip_ok
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic pulse(input int i);
    stb[i] = 1'b1;
    @(negedge sys_clk);
    stb[i] = 1'b0;
  endtask : pulse
  task automatic wait_hi(input int s, input int lim);
    n = 0;
    while (obs[s] !== 1'b1 && n < lim)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk(obs[s] === 1'b1, "wait ran out");
    if (obs[s] !== 1'b1)
      report_and_stop();
  endtask : wait_hi
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial
  begin
    {rst, mode, cmpv, stb, chan, thr, noise, n_mismatch, n_compared} = {1'b1, 2'h0, 8'h00, 7'h00, 3'h0, 8'hff, 1'b0, 64'h0};
    void'($urandom(32'h2351));
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    chk({ramp_charge_enable, dis, setl, efl, input_capture_flag, chsel} === 8'b0110_0000, "reset state");
    for (int i = 0; i < 6; i++)
    begin
      thr  = (i == 0) ? 8'h02 : 8'h10 + 8'($urandom_range(200));
      chan = 3'($urandom);
      pulse(6);
      chk(chsel === chan, "channel not taken");
      pulse(2);
      pulse(0);
      chan = ~chan;
      pulse(6);
      chk(chsel === ~chan, "channel taken while charging");
      wait_hi(0, 300);
      chk(trip_ok(n, int'(thr)), "trip time");
      chk(input_capture_flag === 1'b0, "capture in software mode");
      pulse(1);
      chk(dis === 1'b1 && ramp_charge_enable === 1'b0 && setl === 1'b0, "discharge start");
      wait_hi(1, 20);
      repeat (40) @(negedge sys_clk);
    end
    thr = 8'h00;
    repeat (2) @(negedge sys_clk);
    chk(efl === 1'b1, "flag on rise");
    pulse(2);
    repeat (10) @(negedge sys_clk);
    chk(efl === 1'b0, "flag without new rise");
    thr = 8'hff;
    repeat (2) @(negedge sys_clk);
    thr = 8'h00;
    repeat (2) @(negedge sys_clk);
    chk(efl === 1'b1, "flag after low then high");
    thr  = 8'hff;
    mode = 2'h2;
    pulse(2);
    wait_hi(2, 2100);
    thr = 8'h10 + 8'($urandom_range(100));
    wait_hi(0, 300);
    @(negedge sys_clk);
    chk(input_capture_flag === 1'b1 && ramp_charge_enable === 1'b0, "capture on edge");
    wait_hi(2, 2100);
    chk(ovf === 1'b1, "overflow flag");
    pulse(4);
    pulse(3);
    pulse(2);
    chk({ovf, input_capture_flag, efl} === 3'b000, "flag clears");
    noise = 1'b1;
    @(negedge sys_clk);
    noise = 1'b0;
    @(negedge sys_clk);
    chk(input_capture_flag === 1'b1 && efl === 1'b1, "capture on noise");
    mode = 2'h3;
    cmpv = 8'($urandom);
    thr  = 8'hff;
    pulse(1);
    wait_hi(2, 2100);
    chk(output_compare_flag === 1'b1, "compare flag");
    pulse(5);
    chk(output_compare_flag === 1'b0, "compare flag clear");
    report_and_stop();
  end
endmodule : single_slope_conversion_control_test
